//--- rtl/wdr_top.sv
// wake detection, key off delay and main relay start logic with apb slave
`timescale 1ns/10ps
`include "wdr_defines.svh"

module wdr_top #(
   parameter int IGN_FILT_CYC = `WDR_US2CYC(`WDR_IGN_FILT_US),
   parameter int WK_FILT_CYC = `WDR_US2CYC(`WDR_WK_FILT_US),
   parameter int KOD0_CYC = `WDR_MS2CYC(`WDR_KOD0_MS),
   parameter int KOD1_CYC = `WDR_MS2CYC(`WDR_KOD1_MS),
   parameter int KOD2_CYC = `WDR_MS2CYC(`WDR_KOD2_MS),
   parameter int KOD3_CYC = `WDR_MS2CYC(`WDR_KOD3_MS)
) (
   input wire logic mclk,              // 10 MHz clock
   input wire logic srst,              // sync reset, active high
   input wire logic ce,                // clock enable, freezes all state
   input wire logic psel,              // apb select
   input wire logic penable,           // apb enable
   input wire logic pwrite,            // apb write
   input wire logic [7:0] paddr,       // apb byte address
   input wire logic [31:0] pwdata,     // apb write data
   output logic [31:0] prdata,         // apb read data
   output logic pready,                // apb ready
   output logic pslverr,               // apb error, unmapped address
   input wire logic ignition_in,       // ignition switch level
   input wire logic wake_pin_input,    // wake pin level
   input wire logic bus_wake_event,    // bus wake detected, pulse
   input wire logic timer_compare_hit, // timer equals compare value
   input wire logic battery_below_th,  // battery under detect threshold
   output logic supply_release,        // releases pre-regulator, supply
   output logic relay_drive_output,    // main relay drive
   output logic delayed_ignition_o,    // open-drain level, always low
   output logic delayed_ignition_oe    // high while pulling pin low
);

   // filter counters are 16 bits, off-delay counters 32 bits
   if (IGN_FILT_CYC < 1 || IGN_FILT_CYC > 65535 ||
       WK_FILT_CYC < 1 || WK_FILT_CYC > 65535 ||
       KOD0_CYC < 1 || KOD1_CYC < 1 || KOD2_CYC < 1 || KOD3_CYC < 1) begin
      $error("wdr_top: filter or off-delay count out of range");
   end

   localparam logic [15:0] IGN_LIM = 16'(IGN_FILT_CYC);
   localparam logic [15:0] WK_LIM = 16'(WK_FILT_CYC);

   wdr_pkg::wdr_state_t st_ff; // registered state
   wdr_pkg::wdr_state_t nxt_st; // next state
   logic wr_acc; // write taken this edge
   logic wake_clear_command_bit; // wake clear command pulse
   logic wake_any; // at least one valid wake source
   logic [31:0] stat_word; // operation status register image
   logic [16:0] ign_step; // filter result {level, count}
   logic [16:0] wk_step; // filter result {level, count}

   // one filter step: new level only after lim stable cycles
   function automatic logic [16:0] filt_step(input logic raw,
      input logic lvl, input logic [15:0] cnt, input logic [15:0] lim);
      logic [16:0] r;
      r = {lvl, 16'h0000};
      if (raw != lvl) begin
         if (cnt + 16'h0001 >= lim) begin
            r = {raw, 16'h0000};
         end else begin
            r = {lvl, cnt + 16'h0001};
         end
      end
      return r;
   endfunction

   // off-delay length chosen by the select field
   function automatic logic [31:0] kod_cycles(input logic [1:0] sel);
      logic [31:0] c;
      c = 32'(KOD0_CYC);
      if (sel == 2'h1) begin
         c = 32'(KOD1_CYC);
      end else if (sel == 2'h2) begin
         c = 32'(KOD2_CYC);
      end else if (sel == 2'h3) begin
         c = 32'(KOD3_CYC);
      end
      return c;
   endfunction

   // status image; bits above the fields read as zero
   always_comb begin
      stat_word = 32'h00000000;
      stat_word[`WDR_ST_IGN] = st_ff.ign_f;
      stat_word[`WDR_ST_WK] = st_ff.wk_f;
      stat_word[`WDR_ST_WKLATCH] = (st_ff.wk_st == wdr_pkg::WK_ACTIVE);
      stat_word[`WDR_ST_RELAY] = st_ff.relay;
      stat_word[`WDR_ST_TIMERWK] = st_ff.timer_wk;
      stat_word[`WDR_ST_BUSWK] = st_ff.bus_wk;
      stat_word[`WDR_ST_STARTUP] = st_ff.startup;
   end

   assign wr_acc = psel & penable & st_ff.pready & pwrite;
   assign wake_clear_command_bit = wr_acc & (paddr == `WDR_OFS_CMD) &
                  pwdata[`WDR_CMD_WAKE_CLEAR_COMMAND_BIT];
   // any wake source starts the device
   assign wake_any = st_ff.ign_f | st_ff.bus_wk | st_ff.timer_wk |
                     (st_ff.wk_st == wdr_pkg::WK_ACTIVE);
   // both filters use the same stable-count step
   assign ign_step = filt_step(ignition_in, st_ff.ign_f, st_ff.ign_cnt,
                               IGN_LIM);
   assign wk_step = filt_step(wake_pin_input, st_ff.wk_f, st_ff.wk_cnt,
                              WK_LIM);

   // next-state logic of the whole block
   always_comb begin
      nxt_st = st_ff;
      {nxt_st.ign_f, nxt_st.ign_cnt} = ign_step;
      // wake pin deglitch, same time both edges
      {nxt_st.wk_f, nxt_st.wk_cnt} = wk_step;

      // wake pin fsm; set wins over a clear in the same cycle
      case (st_ff.wk_st)
         wdr_pkg::WK_IDLE: begin
            if (st_ff.wk_f) begin
               nxt_st.wk_st = wdr_pkg::WK_ACTIVE;
            end
         end
         wdr_pkg::WK_ACTIVE: begin
            // clear drops flag even with pin high
            if (wake_clear_command_bit) begin
               nxt_st.wk_st = st_ff.wk_f ? wdr_pkg::WK_CLEARED :
                                           wdr_pkg::WK_IDLE;
            end
         end
         wdr_pkg::WK_CLEARED: begin
            // low pin re-arms; high pin waits here
            if (!st_ff.wk_f) begin
               nxt_st.wk_st = wdr_pkg::WK_IDLE;
            end
         end
         default: begin
            nxt_st.wk_st = wdr_pkg::WK_IDLE;
         end
      endcase

      // sticky timer and bus flags, event beats clear
      nxt_st.timer_wk = timer_compare_hit | (st_ff.timer_wk & ~wake_clear_command_bit);
      nxt_st.bus_wk = bus_wake_event | (st_ff.bus_wk & ~wake_clear_command_bit);

      // host writes to config and command registers
      if (wr_acc && paddr == `WDR_OFS_CFG) begin
         nxt_st.off_delay_select = pwdata[`WDR_CFG_KOD_HI:`WDR_CFG_KOD_LO];
      end
      if (wr_acc && paddr == `WDR_OFS_CMD) begin
         nxt_st.relay_on_command_bit = pwdata[`WDR_CMD_RELAYON];
      end

      if (!st_ff.startup) begin
         // first wake source releases the supplies
         if (wake_any) begin
            nxt_st.startup = 1'b1;
            nxt_st.relay_on_command_bit = st_ff.ign_f | battery_below_th;
            nxt_st.relay = st_ff.ign_f | battery_below_th;
         end
      end else begin
         // ignition forces relay, else host command
         nxt_st.relay = st_ff.ign_f | st_ff.relay_on_command_bit;
      end

      // rise follows filtered ignition, fall after off delay
      if (st_ff.ign_f) begin
         nxt_st.kofd = 1'b1;
         nxt_st.koff_cnt = 32'h00000000;
      end else if (st_ff.kofd) begin
         if (st_ff.koff_cnt + 32'h00000001 >= kod_cycles(st_ff.off_delay_select)) begin
            nxt_st.kofd = 1'b0;
            nxt_st.koff_cnt = 32'h00000000;
         end else begin
            nxt_st.koff_cnt = st_ff.koff_cnt + 32'h00000001;
         end
      end

      // enable kept in its own flop so the pin comes straight from one
      nxt_st.dly_oe = ~nxt_st.kofd;

      // apb: answer prepared in setup, ready in the access cycle
      nxt_st.pready = psel & ~penable;
      nxt_st.pslverr = 1'b0;
      nxt_st.prdata = 32'h00000000;
      if (psel && !penable) begin
         if (paddr == `WDR_OFS_STAT) begin
            // flag and relay visible to host
            nxt_st.prdata = stat_word;
         end else if (paddr == `WDR_OFS_CFG) begin
            nxt_st.prdata = {30'h00000000, st_ff.off_delay_select};
         end else if (paddr == `WDR_OFS_CMD) begin
            // clear bit reads zero, it is a pulse
            nxt_st.prdata = 32'h00000000;
            nxt_st.prdata[`WDR_CMD_RELAYON] = st_ff.relay_on_command_bit;
         end else begin
            nxt_st.pslverr = 1'b1;
         end
      end
   end

   // state register; reset leaves everything inactive
   always_ff @(posedge mclk) begin
      if (srst) begin
         // inactive flag, fsm and delayed output
         st_ff <= '0;
         st_ff.wk_st <= wdr_pkg::WK_IDLE;
         st_ff.dly_oe <= 1'b1;
      end else if (ce) begin
         st_ff <= nxt_st;
      end
   end

   assign prdata = st_ff.prdata;
   assign pready = st_ff.pready;
   assign pslverr = st_ff.pslverr;
   assign supply_release = st_ff.startup;
   assign relay_drive_output = st_ff.relay;
   assign delayed_ignition_o = 1'b0;
   // pin is released (pulled high) while the delayed level is high
   assign delayed_ignition_oe = st_ff.dly_oe;

   default clocking cb @(posedge mclk); endclocking
   default disable iff (srst || !ce);

   sequence wk_rise_s;
      st_ff.wk_st == wdr_pkg::WK_IDLE && st_ff.wk_f;
   endsequence
   sequence wk_clr_high_s;
      st_ff.wk_st == wdr_pkg::WK_ACTIVE && wake_clear_command_bit && st_ff.wk_f;
   endsequence

   wk_set_a: assert property (wk_rise_s |=> stat_word[2])
      else $error("wake rising edge did not set flag");
   wk_clear_a: assert property (wk_clr_high_s |=>
      st_ff.wk_st == wdr_pkg::WK_CLEARED ##1 !stat_word[2] || !ce)
      else $error("wake clear did not drop flag");
   wk_noretrig_a: assert property (st_ff.wk_st == wdr_pkg::WK_CLEARED &&
      st_ff.wk_f |=> st_ff.wk_st != wdr_pkg::WK_ACTIVE)
      else $error("held wake pin re-triggered");
   wk_rearm_a: assert property (st_ff.wk_st == wdr_pkg::WK_CLEARED &&
      !st_ff.wk_f |=> st_ff.wk_st == wdr_pkg::WK_IDLE)
      else $error("low wake pin did not re-arm");
   ign_filter_a: assert property ($changed(st_ff.ign_f) |->
      $past(st_ff.ign_cnt) == IGN_LIM - 16'h0001)
      else $error("ignition filter changed early");
   wk_filter_a: assert property ($changed(st_ff.wk_f) |->
      $past(st_ff.wk_cnt) == WK_LIM - 16'h0001)
      else $error("wake filter changed early");
   supply_a: assert property (wake_any |=> supply_release)
      else $error("supplies not released on wake");
   relay_batt_a: assert property (!st_ff.startup && wake_any &&
      !st_ff.ign_f && !battery_below_th |=> !relay_drive_output)
      else $error("relay on without low battery");
   relay_ign_a: assert property (st_ff.ign_f &&
      (st_ff.startup || wake_any) |=> relay_drive_output)
      else $error("ignition did not hold relay on");
   flag_clr_a: assert property (wake_clear_command_bit && !bus_wake_event &&
      !timer_compare_hit |=> !st_ff.bus_wk && !st_ff.timer_wk)
      else $error("wake clear left a flag set");
   koff_fall_a: assert property ($fell(st_ff.kofd) |->
      $past(st_ff.koff_cnt) == kod_cycles($past(st_ff.off_delay_select)) - 32'h00000001)
      else $error("delayed ignition fell at wrong time");

   // start-up cycle: not started yet and a wake source present
   sequence start_s;
      !st_ff.startup && wake_any;
   endsequence

   koff_rise_a: assert property (st_ff.ign_f |=> !delayed_ignition_oe)
      else $error("delayed ignition did not follow key");
   wk_hold_a: assert property (st_ff.wk_st == wdr_pkg::WK_ACTIVE &&
      !wake_clear_command_bit |=> stat_word[`WDR_ST_WKLATCH])
      else $error("latched wake flag lost");
   start_relay_a: assert property (start_s |=>
      relay_drive_output == ($past(st_ff.ign_f) | $past(battery_below_th)))
      else $error("relay start-up decision wrong");
   relay_cmd_a: assert property (st_ff.startup |=>
      relay_drive_output == ($past(st_ff.ign_f) | $past(st_ff.relay_on_command_bit)))
      else $error("relay did not follow command");
   reset_idle_a: assert property (disable iff (1'b0) srst |=>
      st_ff.wk_st == wdr_pkg::WK_IDLE && delayed_ignition_oe &&
      !supply_release)
      else $error("reset left block active");

endmodule

//--- rtl/wdr_defines.svh
// register offsets, field positions, reset values and timing constants
`ifndef WDR_DEFINES_SVH
`define WDR_DEFINES_SVH
// apb byte offsets (8-bit address space)
`define WDR_OFS_STAT 8'h00
`define WDR_OFS_CFG 8'h04
`define WDR_OFS_CMD 8'h08
// operation_status_register fields
`define WDR_ST_IGN 0
`define WDR_ST_WK 1
`define WDR_ST_WKLATCH 2
`define WDR_ST_RELAY 3
`define WDR_ST_TIMERWK 4
`define WDR_ST_BUSWK 5
`define WDR_ST_STARTUP 6
// operation_config_register fields
`define WDR_CFG_KOD_LO 0
`define WDR_CFG_KOD_HI 1
`define WDR_CFG_RESET 2'h0
// command_register fields
`define WDR_CMD_WAKE_CLEAR_COMMAND_BIT 0
`define WDR_CMD_RELAYON 1
// clock period and filter / off-delay times
`define WDR_CLK_NS 100
`define WDR_IGN_FILT_US 50
`define WDR_WK_FILT_US 50
`define WDR_KOD0_MS 1
`define WDR_KOD1_MS 2
`define WDR_KOD2_MS 4
`define WDR_KOD3_MS 8
// least times round up to whole cycles
`define WDR_US2CYC(t) (((t) * 1000 + `WDR_CLK_NS - 1) / `WDR_CLK_NS)
`define WDR_MS2CYC(t) (((t) * 1000000 + `WDR_CLK_NS - 1) / `WDR_CLK_NS)
`endif

//--- rtl/wdr_pkg.sv
// types of the wake detection and relay start block
package wdr_pkg;
   // wake pin state machine, one-hot
   typedef enum logic [2:0] {
      WK_IDLE = 3'h1,    // inactive, armed for next rising edge
      WK_ACTIVE = 3'h2,  // latched wake flag set
      WK_CLEARED = 3'h4  // cleared while pin still high
   } wdr_wk_st_t;
   // complete state of the block
   typedef struct packed {
      logic ign_f;           // filtered ignition level
      logic [15:0] ign_cnt;  // ignition filter counter
      logic wk_f;            // filtered wake pin level
      logic [15:0] wk_cnt;   // wake pin filter counter
      wdr_wk_st_t wk_st;     // wake pin state
      logic timer_wk;        // timer wake flag
      logic bus_wk;          // bus wake flag
      logic startup;         // start-up done, supplies released
      logic relay_on_command_bit;            // relay-on command bit
      logic relay;           // relay drive output
      logic [1:0] off_delay_select;       // off-delay select
      logic kofd;            // delayed ignition level
      logic dly_oe;          // open-drain enable, high pulls pin low
      logic [31:0] koff_cnt; // off-delay counter
      logic pready;          // apb ready
      logic pslverr;         // apb error
      logic [31:0] prdata;   // apb read data
   } wdr_state_t;
endpackage

//--- verif/wdr_partner.sv
// model of the ignition switch, wake source, bus/timer and pin pull-up
`timescale 1ns/10ps
module wdr_partner (
   input wire logic mclk,       // system clock
   input wire logic key_on,     // switch closed request
   input wire logic wake_on,    // wake source active request
   input wire logic bus_req,    // rising edge asks one bus wake pulse
   input wire logic timer_req,  // rising edge asks one timer hit pulse
   input wire logic dly_ign_o,  // open-drain data from the block
   input wire logic dly_ign_oe, // open-drain enable from the block
   output logic ignition_line,  // level at the ignition input
   output logic wake_line,      // level at the wake pin
   output logic bus_wake,       // one-cycle bus wake flag
   output logic timer_hit,      // one-cycle timer compare hit
   output logic dly_ign_pin     // resolved delayed ignition pin
);
   logic bus_q = 1'h0; // last bus request
   logic tmr_q = 1'h0; // last timer request
   // switch and wake source are plain levels, synchronous to mclk
   assign ignition_line = key_on;
   assign wake_line = wake_on;
   // wake events are single pulses, a held request fires only once
   always_ff @(posedge mclk) begin
      bus_q <= bus_req;
      tmr_q <= timer_req;
   end
   assign bus_wake = bus_req & ~bus_q;
   assign timer_hit = timer_req & ~tmr_q;
   // pull-up: a released open-drain pin reads high, never the last value
   assign dly_ign_pin = dly_ign_oe ? dly_ign_o : 1'h1;
endmodule

//--- verif/wdr_top_tb.sv
// self-checking bench for the wake detection and relay start block
`timescale 1ns/10ps
`include "wdr_defines.svh"
module wdr_top_tb;
   localparam int NF = 4; // shortened filter length
   localparam int KD [4] = '{10, 20, 30, 40}; // shortened off delays
   logic mclk = 1'h0; // 10 MHz clock
   logic srst = 1'h1; // sync reset, held from time zero
   logic ce = 1'h1; // clock enable
   logic psel = 1'h0, penable = 1'h0, pwrite = 1'h0; // apb request
   logic [7:0] paddr = 8'h00; // apb address
   logic [31:0] pwdata = 32'h0, prdata, v; // apb data, last read
   logic pready, pslverr, err; // apb answer
   logic key_on = 1'h0, wake_on = 1'h0; // switch and wake requests
   logic bus_req = 1'h0, timer_req = 1'h0, bat_low = 1'h0; // sources
   logic ign, wk, bus_wk, tmr_hit, relay, supply, dly_o, dly_oe, dly_pin;
   int n_errors = 0; // mismatches seen
   int checked = 0; // comparisons made
   always #50 mclk = ~mclk;
   wdr_top #(.IGN_FILT_CYC(NF), .WK_FILT_CYC(NF), .KOD0_CYC(KD[0]),
      .KOD1_CYC(KD[1]), .KOD2_CYC(KD[2]), .KOD3_CYC(KD[3])) u_dut (
      .mclk(mclk), .srst(srst), .ce(ce), .psel(psel), .penable(penable),
      .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
      .pready(pready), .pslverr(pslverr), .ignition_in(ign),
      .wake_pin_input(wk), .bus_wake_event(bus_wk),
      .timer_compare_hit(tmr_hit), .battery_below_th(bat_low),
      .supply_release(supply), .relay_drive_output(relay),
      .delayed_ignition_o(dly_o), .delayed_ignition_oe(dly_oe));
   wdr_partner u_far (.mclk(mclk), .key_on(key_on), .wake_on(wake_on),
      .bus_req(bus_req), .timer_req(timer_req), .dly_ign_o(dly_o),
      .dly_ign_oe(dly_oe), .ignition_line(ign), .wake_line(wk),
      .bus_wake(bus_wk), .timer_hit(tmr_hit), .dly_ign_pin(dly_pin));
   // verdict and end of run, also reached by a timeout
   task automatic give_verdict();
      if (n_errors == 0 && checked > 0) begin
         $display("Test passed");
      end else begin
         $display("Test failed");
      end
      $finish;
   endtask
   // one comparison, four-state exact
   task automatic check(input string what, input logic [31:0] seen,
      input logic [31:0] exp);
      checked++;
      if (seen !== exp) begin
         n_errors++;
         $display("wrong value %s expected %h seen %h", what, exp, seen);
      end
   endtask
   // let n edges pass, then sample settled outputs
   task automatic cyc(input int n);
      repeat (n) @(posedge mclk);
      #1;
   endtask
   // one apb transfer; request held until pready is seen high
   task automatic apb(input logic wr, input logic [7:0] a,
      input logic [31:0] d);
      int n;
      @(posedge mclk);
      psel <= 1'h1;
      pwrite <= wr;
      paddr <= a;
      pwdata <= d;
      @(posedge mclk);
      penable <= 1'h1;
      #1;
      n = 0;
      while (pready !== 1'h1) begin
         n++;
         if (n > 20) begin
            check("apb ready", 32'h0, 32'h1);
            give_verdict();
         end
         cyc(1);
      end
      // answer taken at the sampling edge, released only after it
      @(posedge mclk);
      v = prdata;
      err = pslverr;
      psel <= 1'h0;
      penable <= 1'h0;
   endtask
   // synchronous reset held three cycles
   task automatic do_reset();
      @(posedge mclk);
      srst <= 1'h1;
      repeat (3) @(posedge mclk);
      srst <= 1'h0;
      cyc(1);
   endtask
   // wake pin: glitch, latch, clear while high, re-arm on low
   task automatic wake_scn();
      do_reset();
      @(posedge mclk);
      wake_on <= 1'h1;
      repeat (NF - 1) @(posedge mclk);
      wake_on <= 1'h0;
      cyc(10);
      check("glitch supply", supply, 32'h0);
      @(posedge mclk);
      wake_on <= 1'h1;
      cyc(NF + 6);
      check("wake supply", supply, 32'h1);
      check("wake relay", relay, 32'h0);
      apb(1'h0, `WDR_OFS_STAT, 32'h0);
      check("wake status", v, 32'h46);
      // host clears while pin stuck high
      apb(1'h1, `WDR_OFS_CMD, 32'h1);
      cyc(10);
      apb(1'h0, `WDR_OFS_STAT, 32'h0);
      check("stuck status", v, 32'h42);
      @(posedge mclk);
      wake_on <= 1'h0;
      cyc(NF + 4);
      apb(1'h0, `WDR_OFS_STAT, 32'h0);
      check("low status", v, 32'h40);
      @(posedge mclk);
      wake_on <= 1'h1;
      cyc(NF + 4);
      apb(1'h0, `WDR_OFS_STAT, 32'h0);
      check("rearm status", v, 32'h46);
      wake_on <= 1'h0;
   endtask
   // ignition: reset state, relay, off delays, relay command
   task automatic ign_scn();
      int n;
      do_reset();
      check("reset oe", dly_oe, 32'h1);
      check("reset relay", relay, 32'h0);
      apb(1'h0, `WDR_OFS_STAT, 32'h0);
      check("reset status", v, 32'h0);
      apb(1'h0, 8'h0C, 32'h0);
      check("unmapped err", err, 32'h1);
      for (int k = 0; k < 4; k++) begin
         apb(1'h1, `WDR_OFS_CFG, k);
         @(posedge mclk);
         key_on <= 1'h1;
         cyc(NF + 4);
         check("ign relay", relay, 32'h1);
         check("ign pin", dly_pin, 32'h1);
         apb(1'h0, `WDR_OFS_STAT, 32'h0);
         check("ign status", v, 32'h49);
         // command low does not drop relay while ignition high
         apb(1'h1, `WDR_OFS_CMD, 32'h0);
         check("ign hold", relay, 32'h1);
         @(posedge mclk);
         key_on <= 1'h0;
         n = 0;
         while (dly_pin === 1'h1 && n < 200) begin
            cyc(1);
            n++;
         end
         check("off delay", n >= KD[k] + NF && n <= KD[k] + NF + 4, 1);
         if (n >= 200) begin
            give_verdict();
         end
      end
      apb(1'h0, `WDR_OFS_CFG, 32'h0);
      check("cfg read", v, 32'h3);
      check("off relay", relay, 32'h0);
      apb(1'h1, `WDR_OFS_CMD, 32'h2);
      cyc(2);
      check("cmd relay", relay, 32'h1);
      apb(1'h0, `WDR_OFS_STAT, 32'h0);
      check("relay status", v, 32'h48);
   endtask
   // clock enable low freezes filters and start-up
   task automatic ce_scn();
      do_reset();
      @(posedge mclk);
      ce <= 1'h0;
      key_on <= 1'h1;
      cyc(NF + 6);
      check("frozen supply", supply, 32'h0);
      @(posedge mclk);
      ce <= 1'h1;
      cyc(NF + 3);
      check("thawed supply", supply, 32'h1);
      check("thawed relay", relay, 32'h1);
      @(posedge mclk);
      key_on <= 1'h0;
   endtask
   // bus and timer start-up at both battery levels, then wake clear
   task automatic other_scn();
      logic [31:0] bit_v;
      for (int i = 0; i < 4; i++) begin
         bit_v = i[0] ? 32'h10 : 32'h20;
         do_reset();
         @(posedge mclk);
         bat_low <= i[1];
         timer_req <= i[0];
         bus_req <= ~i[0];
         cyc(4);
         check("src supply", supply, 32'h1);
         check("src relay", relay, i[1]);
         apb(1'h0, `WDR_OFS_STAT, 32'h0);
         check("src status", v, 32'h40 | bit_v | (i[1] << 3));
         timer_req <= 1'h0;
         bus_req <= 1'h0;
         // relay-on bit rewritten with its start-up value
         apb(1'h1, `WDR_OFS_CMD, 32'h1 | (i[1] << `WDR_CMD_RELAYON));
         cyc(2);
         apb(1'h0, `WDR_OFS_STAT, 32'h0);
         check("clr status", v, 32'h40 | (i[1] << 3));
      end
   endtask
   initial begin
      wake_scn();
      ign_scn();
      ce_scn();
      other_scn();
      give_verdict();
   end
endmodule
